// ==== logic/flash_cb_ctrl.sv ====
// Flash control block: registers, shadow reset load, program/erase control
`timescale 1ns/1ps
module flash_cb_ctrl
    import flash_cb_pkg::*;
#(
    parameter logic [18:0] CB_BASE  = 19'h7FFC0,  // Control block address bits 23:5
    parameter int          ARRAY_AW = 18,         // Array span in address bits
    parameter int          BLK_W    = 3           // Width of the block address field
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic        i_bus_req,
    input  wire logic        i_bus_write,
    input  wire logic [2:0]  i_bus_function_code,
    input  wire logic [23:0] i_bus_addr,
    input  wire logic [15:0] i_bus_wdata,
    output logic             o_addr_ack,
    output logic             o_bus_err,
    output logic [15:0]      o_rdata,
    output logic             o_array_sel,
    output logic             o_burst_buf_sel,
    output logic             o_array_prog,
    output logic             o_array_erase,
    output logic [23:0]      o_array_pe_addr,
    output logic [15:0]      o_array_pe_data,
    output logic             o_hv_active,
    output logic             o_load_busy
);
    cb_state_t              state_r;
    cb_state_t              state_nxt;
    logic [15:0]            module_config_reg;
    logic [15:0]            array_base_hi_r;
    logic [15:0]            array_base_lo_r;
    logic [15:0]            high_voltage_ctrl_reg;
    logic [15:0]            hv_ctrl2_r;
    logic [15:0]            hv1_nxt;
    logic [SH_WORDS*16-1:0] sh_words;
    logic                   lat_valid;
    logic                   lat_shadow;
    logic [23:0]            lat_addr;
    logic [15:0]            lat_data;

    // Offset to shadow word index, and whether the offset has one
    function automatic logic [1:0] sh_index(input logic [4:0] ofs);
        logic [1:0] idx;
        idx = SH_CONFIG;
        if (ofs == OFS_BASE_HI) idx = SH_BASE_HI;
        if (ofs == OFS_BASE_LO) idx = SH_BASE_LO;
        if (ofs == OFS_HV_CTRL2) idx = SH_HV_CTRL2;
        return idx;
    endfunction

    function automatic logic is_shadowed(input logic [4:0] ofs);
        return (ofs == OFS_CONFIG) || (ofs == OFS_BASE_HI) ||
               (ofs == OFS_BASE_LO) || (ofs == OFS_HV_CTRL2);
    endfunction

    // Control block decode; nothing is answered until the shadow load is done
    wire [4:0] ofs       = i_bus_addr[4:0];
    wire       running   = (state_r == ST_RUN);
    wire       cb_hit    = i_bus_req && running && (i_bus_addr[23:5] == CB_BASE);
    wire       super_sp  = (i_bus_function_code == FC_SUPER_DATA);
    wire       cb_take   = cb_hit && super_sp;
    wire       ofs_known = is_shadowed(ofs) || (ofs == OFS_HV_CTRL1);
    wire       cb_wr     = cb_take && ofs_known && i_bus_write;

    // Mode bits
    wire stop_bit  = module_config_reg[CFG_STOP_BIT];
    wire prot_bit  = module_config_reg[CFG_PROT_BIT];
    wire high_voltage_enable       = high_voltage_ctrl_reg[HV_EHV_BIT];
    wire erase_md  = high_voltage_ctrl_reg[HV_ERASE_BIT];
    wire setup_md  = high_voltage_ctrl_reg[HV_SETUP_BIT];

    // Array window from the base registers; STOP hides it, the control block wins any overlap
    wire [23:0] array_base = {array_base_hi_r[7:0], array_base_lo_r};
    wire        array_hit  = i_bus_req && running && !stop_bit && !cb_hit &&
                             (i_bus_addr[23:ARRAY_AW] == array_base[23:ARRAY_AW]);
    wire [BLK_W-1:0] bus_blk = i_bus_addr[ARRAY_AW-1 -: BLK_W];
    wire [BLK_W-1:0] lat_blk = lat_addr[ARRAY_AW-1 -: BLK_W];

    // In setup mode shadowed-register writes go to the latches, not the register
    wire sh_wr_lat  = cb_wr && setup_md && is_shadowed(ofs);
    wire reg_wr     = cb_wr && !sh_wr_lat;
    wire arr_wr_lat = array_hit && i_bus_write && setup_md;
    wire lat_cap    = sh_wr_lat || arr_wr_lat;

    // Program/erase fires at the rising edge of the enable; PROTECT withholds the pulse, not the high voltage
    wire ehv_rise   = hv1_nxt[HV_EHV_BIT] && !high_voltage_enable && running;
    wire fire       = ehv_rise && lat_valid && !prot_bit;
    wire do_erase   = fire && erase_md;
    wire do_prog    = fire && !erase_md;
    wire blk0_erase = do_erase && !lat_shadow && (lat_blk == '0);
    wire sh_erase   = blk0_erase || (do_erase && lat_shadow);
    wire sh_prog    = do_prog && lat_shadow;
    wire arr_prog   = do_prog && !lat_shadow;
    wire arr_erase  = do_erase && !lat_shadow;

    // Next value of high-voltage control 1; enable only sticks in setup mode
    always_comb begin
        hv1_nxt = high_voltage_ctrl_reg;
        if (reg_wr && ofs == OFS_HV_CTRL1) begin
            hv1_nxt = i_bus_wdata & HV1_WR_MASK;
            if (!i_bus_wdata[HV_SETUP_BIT]) begin
                hv1_nxt[HV_EHV_BIT] = 1'b0;
            end
        end
        // Stopping the module drops the programming voltage at once
        if (stop_bit) begin
            hv1_nxt[HV_EHV_BIT] = 1'b0;
        end
    end

    // Sequencer: one load cycle after reset release, then run
    always_comb begin
        unique case (state_r)
            ST_RESET: state_nxt = ST_LOAD;
            ST_LOAD:  state_nxt = ST_RUN;
            ST_RUN:   state_nxt = ST_RUN;
            default:  state_nxt = ST_RESET;
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Shadow words, taken apart for the load
    wire [15:0] sh_cfg  = sh_words[SH_CONFIG*16 +: 16];
    wire [15:0] sh_bhi  = sh_words[SH_BASE_HI*16 +: 16];
    wire [15:0] sh_blo  = sh_words[SH_BASE_LO*16 +: 16];
    wire [15:0] sh_hv2  = sh_words[SH_HV_CTRL2*16 +: 16];
    wire        loading = (state_r == ST_LOAD);

    // Config and base registers: shadow load at reset, bus writes afterwards
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            module_config_reg <= CONFIG_RST;
            array_base_hi_r   <= BASE_HI_RST;
            array_base_lo_r   <= BASE_LO_RST;
            hv_ctrl2_r        <= HV_CTRL2_RST;
        end else if (loading) begin
            module_config_reg <= (CONFIG_RST & ~CONFIG_SH_MASK) |
                                 (sh_cfg & CONFIG_SH_MASK);
            array_base_hi_r   <= sh_bhi & BASE_HI_MASK;
            array_base_lo_r   <= sh_blo;
            hv_ctrl2_r        <= sh_hv2;
        end else if (reg_wr) begin
            if (ofs == OFS_CONFIG)   module_config_reg <= i_bus_wdata & CONFIG_WR_MASK;
            if (ofs == OFS_BASE_HI)  array_base_hi_r   <= i_bus_wdata & BASE_HI_MASK;
            if (ofs == OFS_BASE_LO)  array_base_lo_r   <= i_bus_wdata;
            if (ofs == OFS_HV_CTRL2) hv_ctrl2_r        <= i_bus_wdata;
        end
    end

    // High-voltage control 1 is never shadowed
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            high_voltage_ctrl_reg <= HV_CTRL1_RST;
        end else begin
            high_voltage_ctrl_reg <= hv1_nxt;
        end
    end

    // Read data selection; reserved offsets read zero (undefined to software)
    logic [15:0] rd_mux;
    always_comb begin
        unique case (ofs)
            OFS_CONFIG:   rd_mux = module_config_reg;
            OFS_BASE_HI:  rd_mux = array_base_hi_r;
            OFS_BASE_LO:  rd_mux = array_base_lo_r;
            OFS_HV_CTRL1: rd_mux = high_voltage_ctrl_reg;
            OFS_HV_CTRL2: rd_mux = hv_ctrl2_r;
            default:      rd_mux = 16'h0000;
        endcase
    end

    // Bus answers one cycle after the request; other spaces get no acknowledge
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_addr_ack <= 1'b0;
            o_bus_err  <= 1'b0;
            o_rdata    <= 16'h0000;
        end else begin
            o_addr_ack <= cb_take;
            o_bus_err  <= cb_take && !ofs_known;
            if (cb_take && !i_bus_write) begin
                o_rdata <= rd_mux;
            end
        end
    end

    // Array program/erase strobes carry the latched location, never register state
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_array_prog    <= 1'b0;
            o_array_erase   <= 1'b0;
            o_array_pe_addr <= 24'h000000;
            o_array_pe_data <= 16'h0000;
        end else begin
            o_array_prog  <= arr_prog;
            o_array_erase <= arr_erase;
            if (arr_prog || arr_erase) begin
                o_array_pe_addr <= lat_addr;
                o_array_pe_data <= lat_data;
            end
        end
    end

    // Array read steering is combinational, it rides the same bus cycle
    assign o_array_sel     = array_hit && !i_bus_write;
    assign o_burst_buf_sel = bus_blk[BLK_W-1];
    assign o_hv_active     = high_voltage_enable;
    assign o_load_busy     = !running;

    // Latches freeze while high voltage is on and empty when setup ends
    prog_latch u_latch (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_capture (lat_cap),
        .i_freeze  (high_voltage_enable),
        .i_clear   (!setup_md),
        .i_shadow  (sh_wr_lat),
        .i_addr    (i_bus_addr),
        .i_data    (i_bus_wdata),
        .o_valid   (lat_valid),
        .o_shadow  (lat_shadow),
        .o_addr    (lat_addr),
        .o_data    (lat_data)
    );

    // Shadow row; programmed words show up in registers only via the reset load
    shadow_row_store u_shadow (
        .i_sys_clk (i_sys_clk),
        .i_prog    (sh_prog),
        .i_idx     (sh_index(lat_addr[4:0])),
        .i_data    (lat_data),
        .i_erase   (sh_erase),
        .o_words   (sh_words)
    );
endmodule

// ==== logic/flash_cb_pkg.sv ====
// Constants shared by the flash control block and its helpers
package flash_cb_pkg;
    // Control block geometry and register offsets within it
    localparam int          CB_BYTES       = 32;
    localparam int          CB_OFS_W       = 5;
    localparam logic [4:0]  OFS_CONFIG     = 5'h00;
    localparam logic [4:0]  OFS_BASE_HI    = 5'h08;
    localparam logic [4:0]  OFS_BASE_LO    = 5'h0A;
    localparam logic [4:0]  OFS_HV_CTRL1   = 5'h0C;
    localparam logic [4:0]  OFS_HV_CTRL2   = 5'h0E;
    // Supervisor data space function code
    localparam logic [2:0]  FC_SUPER_DATA  = 3'h5;
    // Register reset values, applied before the shadow load
    localparam logic [15:0] CONFIG_RST     = 16'h4800;
    localparam logic [15:0] BASE_HI_RST    = 16'h0000;
    localparam logic [15:0] BASE_LO_RST    = 16'h0000;
    localparam logic [15:0] HV_CTRL1_RST   = 16'h0000;
    localparam logic [15:0] HV_CTRL2_RST   = 16'h0000;
    // Config fields: which bits come from shadow, which are writable
    localparam logic [15:0] CONFIG_SH_MASK = 16'h93C0;
    localparam logic [15:0] CONFIG_WR_MASK = 16'hFFC0;
    localparam int          CFG_STOP_BIT   = 15;
    localparam int          CFG_PROT_BIT   = 14;
    // High-voltage control 1 fields
    localparam logic [15:0] HV1_WR_MASK    = 16'h0007;
    localparam int          HV_EHV_BIT     = 0;
    localparam int          HV_ERASE_BIT   = 1;
    localparam int          HV_SETUP_BIT   = 2;
    // Base address: high register carries address bits 23:16
    localparam logic [15:0] BASE_HI_MASK   = 16'h00FF;
    // Shadow row: one word per shadowed register, erased state all ones
    localparam int          SH_WORDS       = 4;
    localparam logic [1:0]  SH_CONFIG      = 2'h0;
    localparam logic [1:0]  SH_BASE_HI     = 2'h1;
    localparam logic [1:0]  SH_BASE_LO     = 2'h2;
    localparam logic [1:0]  SH_HV_CTRL2    = 2'h3;
    localparam logic [15:0] ERASED_WORD    = 16'hFFFF;
    // Control sequencer states, Gray coded along reset -> load -> run
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_LOAD  = 2'b01,
        ST_RUN   = 2'b11
    } cb_state_t;
endpackage

// ==== logic/shadow_row_store.sv ====
// Spare-row shadow words: nonvolatile model with program (AND) and erase
`timescale 1ns/1ps
module shadow_row_store
    import flash_cb_pkg::*;
(
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_prog,
    input  wire logic [1:0]             i_idx,
    input  wire logic [15:0]            i_data,
    input  wire logic                   i_erase,
    output logic      [SH_WORDS*16-1:0] o_words
);
    // No reset on purpose: contents must survive master reset
    logic [15:0] mem [SH_WORDS];

    // Programming only clears bits, erase returns every word to all ones
    always_ff @(posedge i_sys_clk) begin
        for (int i = 0; i < SH_WORDS; i++) begin
            if (i_erase) begin
                mem[i] <= ERASED_WORD;
            end else if (i_prog && (i_idx == 2'(i))) begin
                mem[i] <= mem[i] & i_data;
            end
        end
    end

    // Flat view for the reset-time load
    always_comb begin
        for (int i = 0; i < SH_WORDS; i++) begin
            o_words[i*16 +: 16] = mem[i];
        end
    end
endmodule

// ==== logic/prog_latch.sv ====
// Programming latches: address and data of the write to be programmed
`timescale 1ns/1ps
module prog_latch
    import flash_cb_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic        i_capture,
    input  wire logic        i_freeze,
    input  wire logic        i_clear,
    input  wire logic        i_shadow,
    input  wire logic [23:0] i_addr,
    input  wire logic [15:0] i_data,
    output logic             o_valid,
    output logic             o_shadow,
    output logic [23:0]      o_addr,
    output logic [15:0]      o_data
);
    // Last capture before freeze wins; frozen while high voltage is on
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_valid  <= 1'b0;
            o_shadow <= 1'b0;
            o_addr   <= 24'h000000;
            o_data   <= 16'h0000;
        end else if (i_clear) begin
            o_valid  <= 1'b0;
        end else if (i_capture && !i_freeze) begin
            o_valid  <= 1'b1;
            o_shadow <= i_shadow;
            o_addr   <= i_addr;
            o_data   <= i_data;
        end
    end
endmodule

// ==== dv/flash_cb_ctrl_properties.sv ====
// Concurrent checks on the flash control block ports
`timescale 1ns/1ps
module flash_cb_ctrl_checker
    import flash_cb_pkg::*;
#(
    parameter logic [18:0] CB_BASE  = 19'h7FFC0,
    parameter int          ARRAY_AW = 18,
    parameter int          BLK_W    = 3
) (
    input wire logic        i_sys_clk,
    input wire logic        i_rst,
    input wire logic        i_bus_req,
    input wire logic        i_bus_write,
    input wire logic [2:0]  i_bus_function_code,
    input wire logic [23:0] i_bus_addr,
    input wire logic [15:0] i_bus_wdata,
    input wire logic        o_addr_ack,
    input wire logic        o_bus_err,
    input wire logic [15:0] o_rdata,
    input wire logic        o_array_sel,
    input wire logic        o_burst_buf_sel,
    input wire logic        o_array_prog,
    input wire logic        o_array_erase,
    input wire logic [23:0] o_array_pe_addr,
    input wire logic [15:0] o_array_pe_data,
    input wire logic        o_hv_active,
    input wire logic        o_load_busy
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // Accesses the block must answer; reserved offsets are answered too
    wire logic       take_w = i_bus_req && !o_load_busy && (i_bus_addr[23:5] == CB_BASE)
                              && (i_bus_function_code == FC_SUPER_DATA);
    wire logic [4:0] ofs_w  = i_bus_addr[4:0];
    wire logic       rsv_w  = !(ofs_w inside {OFS_CONFIG, OFS_BASE_HI, OFS_BASE_LO,
                                              OFS_HV_CTRL1, OFS_HV_CTRL2});

    ack_timing_a: assert property (take_w |=> o_addr_ack)
        else $error("control block access not acknowledged next cycle");
    ack_cause_a: assert property (o_addr_ack |-> $past(take_w))
        else $error("acknowledge without a supervisor data access");
    reserved_err_a: assert property (take_w && rsv_w |=> o_bus_err)
        else $error("reserved offset without bus error");
    err_cause_a: assert property (o_bus_err |-> o_addr_ack && $past(rsv_w))
        else $error("bus error on a mapped offset");
    burst_sel_a: assert property (o_burst_buf_sel == i_bus_addr[ARRAY_AW-1])
        else $error("burst buffer select not from top block bit");
    load_time_a: assert property ($fell(i_rst) |-> o_load_busy[*2] ##1 !o_load_busy)
        else $error("shadow load did not take two cycles");
    pe_fire_a: assert property (o_array_prog || o_array_erase |-> $rose(o_hv_active))
        else $error("program or erase pulse without enable rising");
    hv_cause_a: assert property ($rose(o_hv_active) |->
        $past(take_w && i_bus_write && ofs_w == OFS_HV_CTRL1 && i_bus_wdata[HV_EHV_BIT]))
        else $error("high voltage enabled without an enable write");

    // Main scenarios reached
    cover property (take_w && rsv_w);
    cover property (o_array_prog);
    cover property ($rose(o_hv_active));
    cover property (o_array_erase);
endmodule

bind flash_cb_ctrl flash_cb_ctrl_checker #(
    .CB_BASE(CB_BASE), .ARRAY_AW(ARRAY_AW), .BLK_W(BLK_W)
) chk_u (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_bus_req(i_bus_req),
    .i_bus_write(i_bus_write), .i_bus_function_code(i_bus_function_code),
    .i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata), .o_addr_ack(o_addr_ack),
    .o_bus_err(o_bus_err), .o_rdata(o_rdata), .o_array_sel(o_array_sel),
    .o_burst_buf_sel(o_burst_buf_sel), .o_array_prog(o_array_prog),
    .o_array_erase(o_array_erase), .o_array_pe_addr(o_array_pe_addr),
    .o_array_pe_data(o_array_pe_data), .o_hv_active(o_hv_active), .o_load_busy(o_load_busy)
);

// ==== dv/bus_host_model.sv ====
// Bus host model: the processor side of the control block register bus
`timescale 1ns/1ps
module bus_host_model (
    input  wire logic        i_sys_clk,
    input  wire logic        i_addr_ack,
    input  wire logic        i_bus_err,
    input  wire logic [15:0] i_rdata,
    output logic             o_req,
    output logic             o_write,
    output logic [2:0]       o_fc,
    output logic [23:0]      o_addr,
    output logic [15:0]      o_wdata
);
    initial begin
        o_req = 1'b0;
        o_write = 1'b0;
        o_fc = 3'h0;
        o_addr = 24'h000000;
        o_wdata = 16'h0000;
    end
    // One strobe cycle; the answer is sampled mid-cycle after the edge that takes it
    task automatic access(input logic w, input logic [2:0] fc, input logic [23:0] a,
                          input logic [15:0] d, output logic ack, output logic err,
                          output logic [15:0] rd);
        @(posedge i_sys_clk);
        o_req <= 1'b1;
        o_write <= w;
        o_fc <= fc;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_sys_clk);
        // Released lines show the inverse so a stale value never looks valid
        o_req <= 1'b0;
        o_write <= ~w;
        o_addr <= ~a;
        o_wdata <= ~d;
        @(negedge i_sys_clk);
        ack = i_addr_ack;
        err = i_bus_err;
        rd = i_rdata;
    endtask
endmodule

// ==== dv/flash_control_block_shadow_bench.sv ====
// Self-checking bench for the flash control block and its shadow words
`timescale 1ns/1ps
module flash_control_block_shadow_bench
    import flash_cb_pkg::*;
();
    localparam logic [18:0] CBB = 19'h7FFC0;
    logic        i_sys_clk, i_rst, req, wr, ack, err, sel, bsel, prog, ers, hv, busy;
    logic [2:0]  fc;
    logic [23:0] addr, pe_addr;
    logic [15:0] wdata, rdata, pe_data, rd;
    logic        got_ack, got_err;
    int          bad_count = 0;
    int          tests_run = 0;

    flash_cb_ctrl #(.CB_BASE(CBB)) dut_u (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_bus_req(req), .i_bus_write(wr),
        .i_bus_function_code(fc), .i_bus_addr(addr), .i_bus_wdata(wdata),
        .o_addr_ack(ack), .o_bus_err(err), .o_rdata(rdata), .o_array_sel(sel),
        .o_burst_buf_sel(bsel), .o_array_prog(prog), .o_array_erase(ers),
        .o_array_pe_addr(pe_addr), .o_array_pe_data(pe_data), .o_hv_active(hv),
        .o_load_busy(busy));
    bus_host_model host_u (
        .i_sys_clk(i_sys_clk), .i_addr_ack(ack), .i_bus_err(err), .i_rdata(rdata),
        .o_req(req), .o_write(wr), .o_fc(fc), .o_addr(addr), .o_wdata(wdata));

    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    endtask
    // Register write and checked register read in supervisor data space
    task automatic wr16(input logic [4:0] o, input logic [15:0] d);
        host_u.access(1'b1, FC_SUPER_DATA, {CBB, o}, d, got_ack, got_err, rd);
    endtask
    task automatic rchk(input string nm, input logic [4:0] o, input logic [15:0] e);
        host_u.access(1'b0, FC_SUPER_DATA, {CBB, o}, 16'h0000, got_ack, got_err, rd);
        chk_bit("read ack", 1'b1, got_ack);
        chk_bit("read err", 1'b0, got_err);
        chk_word(nm, e, rd);
    endtask
    // Master reset, then the two-edge shadow load
    task automatic do_reset();
        @(posedge i_sys_clk);
        i_rst <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        chk_bit("load busy", 1'b0, busy);
    endtask

    // Shadow words start unknown: erase them all, then reload defaults
    task automatic t_erase_shadows();
        wr16(OFS_CONFIG, 16'h0000);
        wr16(OFS_HV_CTRL1, 16'h0006);
        wr16(OFS_CONFIG, 16'h1234);
        wr16(OFS_HV_CTRL1, 16'h0007);
        chk_bit("hv on erase", 1'b1, hv);
        wr16(OFS_HV_CTRL1, 16'h0000);
        do_reset();
        rchk("config", OFS_CONFIG, 16'hDBC0);
        rchk("base hi", OFS_BASE_HI, 16'h00FF);
        rchk("base lo", OFS_BASE_LO, 16'hFFFF);
        rchk("hv ctrl2", OFS_HV_CTRL2, 16'hFFFF);
        rchk("hv ctrl1", OFS_HV_CTRL1, 16'h0000);
    endtask
    // Program the base-high shadow word; the live register must not move
    task automatic t_program_shadow();
        wr16(OFS_CONFIG, 16'h0000);
        rchk("config write", OFS_CONFIG, 16'h0000);
        wr16(OFS_HV_CTRL1, 16'h0004);
        wr16(OFS_BASE_HI, 16'h0056);
        wr16(OFS_BASE_HI, 16'h0012);
        rchk("base hi latched", OFS_BASE_HI, 16'h00FF);
        wr16(OFS_HV_CTRL1, 16'h0005);
        chk_bit("hv on program", 1'b1, hv);
        chk_bit("no array prog", 1'b0, prog);
        rchk("base hi before reset", OFS_BASE_HI, 16'h00FF);
        wr16(OFS_HV_CTRL1, 16'h0000);
        do_reset();
        rchk("base hi after reset", OFS_BASE_HI, 16'h0012);
        rchk("config shadow kept", OFS_CONFIG, 16'hDBC0);
    endtask
    // Wrong space, outside the block, and every even reserved offset
    task automatic t_space_reserved();
        host_u.access(1'b0, 3'h1, {CBB, OFS_BASE_HI}, 16'h0000, got_ack, got_err, rd);
        chk_bit("user space ack", 1'b0, got_ack);
        host_u.access(1'b0, FC_SUPER_DATA, {CBB + 19'h1, 5'h08}, 16'h0000,
                      got_ack, got_err, rd);
        chk_bit("past block ack", 1'b0, got_ack);
        for (int o = 2; o < 32; o += 2) begin
            if (o == 8 || o == 10 || o == 12 || o == 14) continue;
            wr16(o[4:0], 16'h0000);
            chk_bit("reserved ack", 1'b1, got_ack);
            chk_bit("reserved err", 1'b1, got_err);
        end
        rchk("hv ctrl2 intact", OFS_HV_CTRL2, 16'hFFFF);
    endtask
    // Burst buffer follows the top block bit; looked at while the array read stands
    task automatic t_burst();
        wr16(OFS_CONFIG, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            fork
                host_u.access(1'b0, FC_SUPER_DATA, {6'h04, i[0], 17'h00000}, 16'h0000,
                              got_ack, got_err, rd);
                begin
                    @(posedge i_sys_clk);
                    @(negedge i_sys_clk);
                    chk_bit("burst select", i[0], bsel);
                    chk_bit("array select", 1'b1, sel);
                end
            join
        end
    endtask
    // Array program (last write wins), then a block 0 erase that takes the shadow row along
    task automatic t_array_pe();
        wr16(OFS_CONFIG, 16'h0000);
        wr16(OFS_HV_CTRL1, 16'h0004);
        host_u.access(1'b1, FC_SUPER_DATA, 24'h128010, 16'h005A, got_ack, got_err, rd);
        host_u.access(1'b1, FC_SUPER_DATA, 24'h128004, 16'h00A5, got_ack, got_err, rd);
        wr16(OFS_HV_CTRL1, 16'h0005);
        chk_bit("array prog", 1'b1, prog);
        chk_word("prog data", 16'h00A5, pe_data);
        chk_word("prog addr low", 16'h8004, pe_addr[15:0]);
        wr16(OFS_HV_CTRL1, 16'h0000);
        wr16(OFS_HV_CTRL1, 16'h0006);
        host_u.access(1'b1, FC_SUPER_DATA, 24'h100000, 16'h0000, got_ack, got_err, rd);
        wr16(OFS_HV_CTRL1, 16'h0007);
        chk_bit("array erase", 1'b1, ers);
        chk_word("erase addr high", 16'h0010, {8'h00, pe_addr[23:16]});
        wr16(OFS_HV_CTRL1, 16'h0000);
        do_reset();
        rchk("base hi erased", OFS_BASE_HI, 16'h00FF);
    endtask

    initial begin
        i_rst = 1'b1;
        repeat (16) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        t_erase_shadows();
        t_program_shadow();
        t_space_reserved();
        t_burst();
        t_array_pe();
        give_verdict();
    end
    // Whole run takes well under a thousand cycles
    initial begin
        #200000;
        bad_count++;
        give_verdict();
    end
endmodule
